/* File: shared/gsci_params.svh */
// Purpose: constants for the gas sensor I2C command front end
// Assumes: core clock 50 MHz, I2C standard-mode target
// Notes:   times in ms; cycle counts derived in the core
// Function
// - Idle and ready only after power-up delay
// - Ready again within soft reset time
// - Answer only the fixed 7-bit address
// - Every command is a 16-bit code
// - Words travel high byte first
// - Checksum byte follows every data word, not the command code
// - Write, send, read, send-then-fetch sequences
// - Read header refused until execution time ends
// - Start code begins five-second periodic sampling
// - Halt code returns to idle, 500 ms
// - Calibration is send-then-fetch, 400 ms
// - Only measurement, halt and pressure codes permitted while sampling
// - Fetch empties buffer; empty fetch refused
// - Settings commands other than pressure accepted only in idle
`ifndef GSCI_PARAMS_SVH
`define GSCI_PARAMS_SVH
`define GS_I2C_ADDR      7'h62
`define GS_CLK_KHZ       50000
`define GS_T_PWRUP_MS    1000
`define GS_T_SOFTRST_MS  1000
`define GS_T_UPDATE_MS   5000
`define GS_T_CFG_MS      14'd1
`define GS_T_STOP_MS     14'd500
`define GS_T_FRC_MS      14'd400
`define GS_T_PERSIST_MS  14'd800
`define GS_T_SELFTEST_MS 14'd10000
`define GS_T_FRESET_MS   14'd1200
`define GS_T_REINIT_MS   14'd20
`define GS_CMD_START     16'h21b1
`define GS_CMD_MEAS      16'hec05
`define GS_CMD_STOP      16'h3f86
`define GS_CMD_SET_TOFF  16'h241d
`define GS_CMD_GET_TOFF  16'h2318
`define GS_CMD_SET_ALT   16'h2427
`define GS_CMD_GET_ALT   16'h2322
`define GS_CMD_SET_PRES  16'he000
`define GS_CMD_FRC       16'h362f
`define GS_CMD_SET_ASC   16'h2416
`define GS_CMD_GET_ASC   16'h2313
`define GS_CMD_PERSIST   16'h3615
`define GS_CMD_SERIAL    16'h3682
`define GS_CMD_SELFTEST  16'h3639
`define GS_CMD_FRESET    16'h3632
`define GS_CMD_REINIT    16'h3646
`define GS_CRC_POLY      8'h07
`define GS_CRC_INIT      8'h00
`define GS_WORD_W        16
`define GS_BIT_LAST      3'h7
`define GS_WB_CMDH       3'h0
`define GS_WB_CMDL       3'h1
`define GS_WB_WDH        3'h2
`define GS_WB_WDL        3'h3
`define GS_WB_CRC        3'h4
`define GS_WB_DONE       3'h5
`define GS_PH_CRC        2'h2
`define GS_LEN_ONE       2'h1
`define GS_LEN_MEAS      2'h3
`define GS_TOFF_DEF      16'h05da
`define GS_ALT_DEF       16'h0000
`define GS_PRES_DEF      16'h0000
`define GS_ASC_DEF       16'h0001
`define GS_SELFTEST_OK   16'h0000
`define GS_SERIAL_DEF    48'h0123_4567_89ab
`endif

/* File: shared/gsci_pkg.sv */
// Purpose: types for the gas sensor I2C command front end
// Assumes: constants come from gsci_params.svh
// Notes:   structs carry grouped samples and settings
package gsci_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK, ST_WAIT
    } gsci_bus_st_t;
    typedef enum logic [1:0] {
        RS_NONE, RS_MEAS, RS_BUF, RS_FRC
    } gsci_rsel_t;
    typedef struct packed {
        logic [15:0] co2;
        logic [15:0] temp;
        logic [15:0] rh;
    } gsci_meas_t;
    typedef struct packed {
        logic [15:0] toff;
        logic [15:0] alt;
        logic [15:0] pres;
        logic [15:0] asc;
    } gsci_set_t;
endpackage

/* File: core/gsci_core.sv */
// Purpose: I2C target command interpreter of the gas sensor
// Assumes: SCL/SDA are open-drain pins, sampled by CORE_CLK
// Notes:   SCL at most 100 kHz, so bit timing is coarse here
`include "gsci_params.svh"
module gsci_core #(
    parameter int unsigned P_CYC_PER_MS = `GS_CLK_KHZ,
    parameter logic [47:0] P_SERIAL     = `GS_SERIAL_DEF // Arbitrary
) (
    input  wire logic               CORE_CLK,   // Core clock
    input  wire logic               RST_N,      // Async reset
    input  wire logic               SCL_I,      // Bus clock pin
    input  wire logic               SDA_I,      // Bus data pin
    output logic                    SDA_O,      // Data drive level
    output logic                    SDA_OE,     // Data pulled low
    input  wire gsci_pkg::gsci_meas_t MEAS,     // Live sample
    input  wire logic [15:0]        CAL_CORR,   // Calibration result
    output gsci_pkg::gsci_set_t     SETTINGS,   // Current settings
    output logic                    MODE_PERIODIC, // Sampling
    output logic                    READY,      // Init complete
    output logic                    CMD_STB,    // Command accepted
    output logic [15:0]             CMD_CODE    // Accepted code
);
    import gsci_pkg::*;

    localparam int unsigned PWRUP_CYC = `GS_T_PWRUP_MS * P_CYC_PER_MS;
    localparam int unsigned SOFT_CYC  = `GS_T_SOFTRST_MS * P_CYC_PER_MS;
    localparam int unsigned UPD_CYC   = `GS_T_UPDATE_MS * P_CYC_PER_MS;

    logic [1:0]   scl_sync_reg;
    logic [1:0]   sda_sync_reg;
    logic         scl_d_reg;
    logic         sda_d_reg;
    gsci_bus_st_t st_reg;
    logic [2:0]   bcnt_reg;
    logic [7:0]   sh_reg;
    logic         got_reg;
    logic         addr_ph_reg;
    logic         rw_reg;
    logic         oe_reg;
    logic         wr_txn_reg;
    logic [2:0]   wcnt_reg;
    logic [15:0]  cmd_reg;
    logic [15:0]  word_reg;
    logic         word_ok_reg;
    logic [31:0]  init_cnt_reg;
    logic [31:0]  exec_cnt_reg;
    logic         ready_reg;
    logic         periodic_reg;
    logic [31:0]  per_cnt_reg;
    gsci_meas_t   res_buf_reg;
    logic         res_valid_reg;
    gsci_rsel_t   rsel_reg;
    logic [15:0]  rd_buf_reg [3];
    logic [1:0]   rd_len_reg;
    logic [1:0]   rd_idx_reg;
    logic [1:0]   rd_ph_reg;
    gsci_set_t    set_reg;
    logic         stb_reg;
    logic [15:0]  code_reg;

    // Checksum over one word, MSB first
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = `GS_CRC_INIT;
        for (int i = `GS_WORD_W - 1; i >= 0; i--) begin
            if (c[7] ^ w[i]) begin
                c = {c[6:0], 1'b0} ^ `GS_CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction

    // Codes allowed while sampling runs
    function automatic logic meas_ok(input logic [15:0] c);
        return c == `GS_CMD_MEAS || c == `GS_CMD_STOP ||
               c == `GS_CMD_SET_PRES;
    endfunction

    // Worst-case execution time in ms
    function automatic logic [13:0] exec_ms(input logic [15:0] c);
        case (c)
            `GS_CMD_STOP:     return `GS_T_STOP_MS;
            `GS_CMD_FRC:      return `GS_T_FRC_MS;
            `GS_CMD_PERSIST:  return `GS_T_PERSIST_MS;
            `GS_CMD_SELFTEST: return `GS_T_SELFTEST_MS;
            `GS_CMD_FRESET:   return `GS_T_FRESET_MS;
            `GS_CMD_REINIT:   return `GS_T_REINIT_MS;
            `GS_CMD_START:    return 14'h0;
            default:          return `GS_T_CFG_MS;
        endcase
    endfunction

    // Pins pass two flops; a third stage only for edge finding
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_d_reg    <= 1'b1;
            sda_d_reg    <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], SCL_I};
            sda_sync_reg <= {sda_sync_reg[0], SDA_I};
            scl_d_reg    <= scl_sync_reg[1];
            sda_d_reg    <= sda_sync_reg[1];
        end
    end

    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic byte_ev;
    logic addr_hit;
    logic rd_avail;
    logic ack_addr;
    logic hdr_rd_ev;
    logic hdr_wr_ev;
    logic wbyte_ev;
    logic tx_adv;
    logic exec_go;
    logic [7:0] cur_byte;
    logic [15:0] cur_word;

    // Bus events; START and STOP frame every transaction
    assign scl      = scl_sync_reg[1];
    assign sda      = sda_sync_reg[1];
    assign scl_rise = scl & ~scl_d_reg;
    assign scl_fall = ~scl & scl_d_reg;
    assign start_ev = scl & scl_d_reg & sda_d_reg & ~sda;
    assign stop_ev  = scl & scl_d_reg & ~sda_d_reg & sda;
    assign byte_ev  = (st_reg == ST_RX) & scl_fall & got_reg;

    // Header decode: address, readiness, result availability
    assign addr_hit = sh_reg[7:1] == `GS_I2C_ADDR;
    assign rd_avail = (rsel_reg != RS_NONE) &&
                      (rsel_reg != RS_MEAS || res_valid_reg);
    assign ack_addr = addr_hit & ready_reg & (~sh_reg[0] |
                      (exec_cnt_reg == 32'h0 & rd_avail));
    assign hdr_rd_ev = byte_ev & addr_ph_reg & ack_addr & sh_reg[0];
    assign hdr_wr_ev = byte_ev & addr_ph_reg & ack_addr & ~sh_reg[0];
    assign wbyte_ev  = byte_ev & ~addr_ph_reg & wr_txn_reg;
    assign tx_adv    = (st_reg == ST_TXACK) & scl_rise & ~sda;

    // Busy commands are dropped, not queued; the controller must wait
    assign exec_go = stop_ev & wr_txn_reg & (wcnt_reg > `GS_WB_CMDL) &
                     ready_reg & (exec_cnt_reg == 32'h0) &
                     (~periodic_reg | meas_ok(cmd_reg));

    // Outgoing byte: high, low, checksum per word
    assign cur_word = rd_buf_reg[rd_idx_reg];
    always_comb begin
        if (rd_idx_reg >= rd_len_reg) begin
            cur_byte = 8'hff;
        end else if (rd_ph_reg == `GS_PH_CRC) begin
            cur_byte = crc8(cur_word);
        end else if (rd_ph_reg == 2'h0) begin
            cur_byte = cur_word[15:8];
        end else begin
            cur_byte = cur_word[7:0];
        end
    end

    // Bit-level target: shift in on rise, drive on fall
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_reg      <= ST_IDLE;
            bcnt_reg    <= 3'h0;
            sh_reg      <= 8'h00;
            got_reg     <= 1'b0;
            addr_ph_reg <= 1'b0;
            rw_reg      <= 1'b0;
            oe_reg      <= 1'b0;
        end else if (start_ev) begin
            st_reg      <= ST_RX;
            bcnt_reg    <= 3'h0;
            got_reg     <= 1'b0;
            addr_ph_reg <= 1'b1;
            oe_reg      <= 1'b0;
        end else if (stop_ev) begin
            st_reg <= ST_IDLE;
            oe_reg <= 1'b0;
        end else begin
            case (st_reg)
                ST_RX: begin
                    if (scl_rise) begin
                        sh_reg   <= {sh_reg[6:0], sda};
                        bcnt_reg <= bcnt_reg + 3'h1;
                        got_reg  <= bcnt_reg == `GS_BIT_LAST;
                    end else if (byte_ev) begin
                        got_reg <= 1'b0;
                        if (addr_ph_reg) begin
                            rw_reg <= sh_reg[0];
                        end
                        if (!addr_ph_reg || ack_addr) begin
                            oe_reg <= 1'b1;
                            st_reg <= ST_ACK;
                        end else begin
                            st_reg <= ST_WAIT;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        addr_ph_reg <= 1'b0;
                        bcnt_reg    <= 3'h0;
                        if (rw_reg) begin
                            sh_reg <= {cur_byte[6:0], 1'b0};
                            oe_reg <= ~cur_byte[7];
                            st_reg <= ST_TX;
                        end else begin
                            oe_reg <= 1'b0;
                            st_reg <= ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bcnt_reg == `GS_BIT_LAST) begin
                            oe_reg <= 1'b0;
                            st_reg <= ST_TXACK;
                        end else begin
                            oe_reg   <= ~sh_reg[7];
                            sh_reg   <= {sh_reg[6:0], 1'b0};
                            bcnt_reg <= bcnt_reg + 3'h1;
                        end
                    end
                end
                ST_TXACK: begin
                    if (scl_rise && sda) begin
                        st_reg <= ST_WAIT; // Controller ends the read
                    end else if (scl_fall) begin
                        sh_reg   <= {cur_byte[6:0], 1'b0};
                        oe_reg   <= ~cur_byte[7];
                        bcnt_reg <= 3'h0;
                        st_reg   <= ST_TX;
                    end
                end
                default: begin
                    oe_reg <= 1'b0;
                end
            endcase
        end
    end

    // Write capture: command, then word and its checksum
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_txn_reg  <= 1'b0;
            wcnt_reg    <= `GS_WB_CMDH;
            cmd_reg     <= 16'h0000;
            word_reg    <= 16'h0000;
            word_ok_reg <= 1'b0;
        end else if (start_ev || stop_ev) begin
            wr_txn_reg <= 1'b0;
        end else if (hdr_wr_ev) begin
            wr_txn_reg  <= 1'b1;
            wcnt_reg    <= `GS_WB_CMDH;
            word_ok_reg <= 1'b0;
        end else if (wbyte_ev) begin
            case (wcnt_reg)
                `GS_WB_CMDH: cmd_reg[15:8]  <= sh_reg;
                `GS_WB_CMDL: cmd_reg[7:0]   <= sh_reg;
                `GS_WB_WDH:  word_reg[15:8] <= sh_reg;
                `GS_WB_WDL:  word_reg[7:0]  <= sh_reg;
                `GS_WB_CRC:  word_ok_reg <= sh_reg == crc8(word_reg);
                default: ;
            endcase
            if (wcnt_reg != `GS_WB_DONE) begin
                wcnt_reg <= wcnt_reg + 3'h1;
            end
        end
    end

    // Power-up, soft reset and execution timers
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            init_cnt_reg <= PWRUP_CYC;
            ready_reg    <= 1'b0;
            exec_cnt_reg <= 32'h0;
        end else if (exec_go && cmd_reg == `GS_CMD_REINIT) begin
            init_cnt_reg <= SOFT_CYC;
            ready_reg    <= 1'b0;
            exec_cnt_reg <= 32'h0;
        end else begin
            if (init_cnt_reg != 32'h0) begin
                init_cnt_reg <= init_cnt_reg - 32'h1;
                ready_reg    <= init_cnt_reg == 32'h1;
            end
            if (exec_go) begin
                exec_cnt_reg <= 32'(exec_ms(cmd_reg)) * P_CYC_PER_MS;
            end else if (exec_cnt_reg != 32'h0) begin
                exec_cnt_reg <= exec_cnt_reg - 32'h1;
            end
        end
    end

    // Periodic sampling and the one-shot result buffer
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            periodic_reg  <= 1'b0;
            per_cnt_reg   <= 32'h0;
            res_buf_reg   <= '0;
            res_valid_reg <= 1'b0;
        end else begin
            if (exec_go && cmd_reg == `GS_CMD_START) begin
                periodic_reg <= 1'b1;
                per_cnt_reg  <= UPD_CYC;
            end else if (exec_go && (cmd_reg == `GS_CMD_STOP ||
                         cmd_reg == `GS_CMD_REINIT)) begin
                periodic_reg <= 1'b0;
            end else if (periodic_reg) begin
                per_cnt_reg <= (per_cnt_reg == 32'h1) ? UPD_CYC :
                               per_cnt_reg - 32'h1;
            end
            // A new sample wins over a fetch in the same cycle
            if (periodic_reg && per_cnt_reg == 32'h1) begin
                res_buf_reg   <= MEAS;
                res_valid_reg <= 1'b1;
            end else if (hdr_rd_ev && rsel_reg == RS_MEAS) begin
                res_valid_reg <= 1'b0;
            end
        end
    end

    // Read source chosen by the command; sample and calibration filled at read header
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rsel_reg   <= RS_NONE;
            rd_buf_reg <= '{default: 16'h0000};
            rd_len_reg <= 2'h0;
            rd_idx_reg <= 2'h0;
            rd_ph_reg  <= 2'h0;
        end else if (exec_go) begin
            rsel_reg   <= RS_BUF;
            rd_len_reg <= `GS_LEN_ONE;
            case (cmd_reg)
                `GS_CMD_MEAS:     rsel_reg <= RS_MEAS;
                `GS_CMD_FRC:      rsel_reg <= RS_FRC;
                `GS_CMD_GET_TOFF: rd_buf_reg[0] <= set_reg.toff;
                `GS_CMD_GET_ALT:  rd_buf_reg[0] <= set_reg.alt;
                `GS_CMD_GET_ASC:  rd_buf_reg[0] <= set_reg.asc;
                `GS_CMD_SELFTEST: rd_buf_reg[0] <= `GS_SELFTEST_OK;
                `GS_CMD_SERIAL: begin
                    rd_buf_reg <= '{P_SERIAL[47:32], P_SERIAL[31:16],
                                    P_SERIAL[15:0]};
                    rd_len_reg <= `GS_LEN_MEAS;
                end
                default: rsel_reg <= RS_NONE;
            endcase
        end else if (hdr_rd_ev) begin
            rsel_reg   <= RS_NONE; // One fetch per command
            rd_idx_reg <= 2'h0;
            rd_ph_reg  <= 2'h0;
            if (rsel_reg == RS_MEAS) begin
                rd_buf_reg <= '{res_buf_reg.co2, res_buf_reg.temp,
                                res_buf_reg.rh};
                rd_len_reg <= `GS_LEN_MEAS;
            end else if (rsel_reg == RS_FRC) begin
                rd_buf_reg[0] <= CAL_CORR;
            end
        end else if (tx_adv) begin
            if (rd_ph_reg == `GS_PH_CRC) begin
                rd_ph_reg  <= 2'h0;
                rd_idx_reg <= rd_idx_reg + 2'h1;
            end else begin
                rd_ph_reg <= rd_ph_reg + 2'h1;
            end
        end
    end

    // Settings; a word with a bad checksum is dropped
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            set_reg <= '{`GS_TOFF_DEF, `GS_ALT_DEF, `GS_PRES_DEF,
                         `GS_ASC_DEF};
        end else if (exec_go && cmd_reg == `GS_CMD_FRESET) begin
            set_reg <= '{`GS_TOFF_DEF, `GS_ALT_DEF, `GS_PRES_DEF,
                         `GS_ASC_DEF};
        end else if (exec_go && word_ok_reg) begin
            case (cmd_reg)
                `GS_CMD_SET_TOFF: set_reg.toff <= word_reg;
                `GS_CMD_SET_ALT:  set_reg.alt  <= word_reg;
                `GS_CMD_SET_PRES: set_reg.pres <= word_reg;
                `GS_CMD_SET_ASC:  set_reg.asc  <= word_reg;
                default: ;
            endcase
        end
    end

    // Accepted-command strobe to the sensor core
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            stb_reg  <= 1'b0;
            code_reg <= 16'h0000;
        end else begin
            stb_reg <= exec_go;
            if (exec_go) begin
                code_reg <= cmd_reg;
            end
        end
    end

    // Open drain: level is always low, only the enable moves
    assign SDA_O         = 1'b0;
    assign SDA_OE        = oe_reg;
    assign SETTINGS      = set_reg;
    assign MODE_PERIODIC = periodic_reg;
    assign READY         = ready_reg;
    assign CMD_STB       = stb_reg;
    assign CMD_CODE      = code_reg;
endmodule

/* File: test/gsci_core_asserts.sv */
// Purpose: property checks on the command front end ports
// Assumes: one clock domain, bound into gsci_core
// Notes:   delays scale with P_CYC_PER_MS
module gsci_core_asserts #(
    parameter int unsigned P_CYC_PER_MS = 50000
) (
    input wire logic                 CORE_CLK,      // Core clock
    input wire logic                 RST_N,         // Async reset
    input wire logic                 SDA_O,         // Drive level
    input wire logic                 SDA_OE,        // Pulls data low
    input wire gsci_pkg::gsci_set_t  SETTINGS,      // Settings
    input wire logic                 MODE_PERIODIC, // Sampling
    input wire logic                 READY,         // Init done
    input wire logic                 CMD_STB,       // Command pulse
    input wire logic [15:0]          CMD_CODE       // Last code
);
    localparam int unsigned PW = 1000 * P_CYC_PER_MS;
    int unsigned lo_cnt_reg;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    // Cycles not ready
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N)
            lo_cnt_reg <= 0;
        else
            lo_cnt_reg <= READY ? 0 : lo_cnt_reg + 1;
    end
    // Port relations
    chk_open_drain: assert property (
        SDA_OE |-> SDA_O == 1'b0) else $error("data driven high");
    chk_quiet_unready: assert property (
        !READY |-> !SDA_OE) else $error("answer while unready");
    chk_ready_delay: assert property (
        $rose(READY) |-> lo_cnt_reg >= PW - 2 && lo_cnt_reg <= PW + 2)
        else $error("ready delay wrong");
    chk_ready_drop: assert property (
        $fell(READY) |-> CMD_CODE == 16'h3646) else $error("ready lost");
    chk_strobe_pulse: assert property (
        CMD_STB |=> !CMD_STB) else $error("strobe too long");
    chk_code_strobe: assert property (
        $changed(CMD_CODE) |-> CMD_STB) else $error("code without strobe");
    chk_periodic_enter: assert property (
        $rose(MODE_PERIODIC) |-> CMD_CODE == 16'h21b1)
        else $error("bad start code");
    chk_periodic_leave: assert property (
        $fell(MODE_PERIODIC) |-> CMD_CODE == 16'h3f86)
        else $error("bad halt code");
    chk_periodic_filter: assert property (
        CMD_STB && $past(MODE_PERIODIC) |->
        CMD_CODE inside {16'hec05, 16'h3f86, 16'he000})
        else $error("code accepted while sampling");
    chk_setting_cause: assert property (
        $changed(SETTINGS) |-> CMD_STB) else $error("setting moved alone");
    chk_setting_idle: assert property (
        $changed(SETTINGS) && MODE_PERIODIC |-> CMD_CODE == 16'he000)
        else $error("setting changed while sampling");
    // Main scenarios reached
    cov_stb_periodic: cover property (CMD_STB && MODE_PERIODIC);
    cov_soft_reset: cover property ($fell(READY));
    cov_halt: cover property ($fell(MODE_PERIODIC));
endmodule
bind gsci_core gsci_core_asserts #(.P_CYC_PER_MS(P_CYC_PER_MS)) u_chk (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
    .SETTINGS(SETTINGS), .MODE_PERIODIC(MODE_PERIODIC), .READY(READY),
    .CMD_STB(CMD_STB), .CMD_CODE(CMD_CODE));

/* File: test/gsci_ctl.sv */
// Purpose: bus controller model facing the sensor front end
// Assumes: data line released goes to the pull-up level
// Notes:   160 ns bus clock; clock stands high between frames
module gsci_ctl (
    output logic      scl_o,  // Bus clock
    output logic      sda_dn, // Pull data low
    input  wire logic sda_i   // Resolved data line
);
    timeunit 1ns;
    timeprecision 1ns;
    // Bus idle with both lines released
    initial begin
        scl_o = 1'b1;
        sda_dn = 1'b0;
    end
    // Odd offset keeps frames out of phase with the core clock
    task automatic start_c;
        #87 sda_dn = 1'b1;
        #80 scl_o = 1'b0;
    endtask
    // Set data while clock low, sample at end of high
    task automatic bit_c(input logic b, output logic r);
        #40 sda_dn = !b;
        #40 scl_o = 1'b1;
        #80 r = sda_i;
        scl_o = 1'b0;
    endtask
    task automatic byte_w(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_c(d[i], r);
        bit_c(1'b1, r);
        ack = !r;
    endtask
    // Master NACKs the last byte
    task automatic byte_r(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_c(1'b1, r);
            d[i] = r;
        end
        bit_c(last, r);
    endtask
    task automatic stop_c;
        #40 sda_dn = 1'b1;
        #40 scl_o = 1'b1;
        #80 sda_dn = 1'b0;
        #80;
    endtask
endmodule

/* File: test/gsci_core_tb_top.sv */
// Purpose: self-checking bench of the command front end
// Assumes: times shortened to 5 core cycles per ms
// Notes:   sample and calibration inputs held constant
module gsci_core_tb_top;
    import gsci_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned CYC = 5;
    logic clk, rst_n, scl, sda_dn, dev_oe, dev_o, rdy, stb, per;
    logic [15:0] code;
    logic [15:0] cal = 16'h1234;
    gsci_meas_t meas = {16'h01f4, 16'h6667, 16'h5eb9};
    gsci_set_t sets;
    logic [7:0] q [0:8];
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    // Open-drain data line with pull-up
    wire sda = (dev_oe ? dev_o : 1'b1) && !sda_dn;
    gsci_core #(.P_CYC_PER_MS(CYC)) u_gsci_core (
        .CORE_CLK(clk), .RST_N(rst_n), .SCL_I(scl), .SDA_I(sda),
        .SDA_O(dev_o), .SDA_OE(dev_oe), .MEAS(meas), .CAL_CORR(cal),
        .SETTINGS(sets), .MODE_PERIODIC(per), .READY(rdy),
        .CMD_STB(stb), .CMD_CODE(code));
    gsci_ctl u_gsci_ctl (.scl_o(scl), .sda_dn(sda_dn), .sda_i(sda));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic results;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c = 8'h00;
        for (int i = 15; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    // Header only, then stop
    task automatic probe(input logic [7:0] h, input logic e);
        logic a;
        u_gsci_ctl.start_c();
        u_gsci_ctl.byte_w(h, a);
        chk("header ack", a, e);
        u_gsci_ctl.stop_c();
    endtask
    // Gap outlasts 1 ms busy
    task automatic cmd(input logic [15:0] c, input logic wd = 1'b0,
                       input logic [15:0] w = 16'h0000,
                       input logic [7:0] k = 8'h00);
        logic a;
        u_gsci_ctl.start_c();
        u_gsci_ctl.byte_w(8'hc4, a);
        u_gsci_ctl.byte_w(c[15:8], a);
        u_gsci_ctl.byte_w(c[7:0], a);
        if (wd) begin
            u_gsci_ctl.byte_w(w[15:8], a);
            u_gsci_ctl.byte_w(w[7:0], a);
            u_gsci_ctl.byte_w(k, a);
        end
        u_gsci_ctl.stop_c();
        repeat (20) @(posedge clk);
        #1;
    endtask
    task automatic rd(input int n);
        logic a;
        u_gsci_ctl.start_c();
        u_gsci_ctl.byte_w(8'hc5, a);
        chk("read ack", a, 1'b1);
        for (int i = 0; i < n && a; i++) u_gsci_ctl.byte_r(i == n - 1, q[i]);
        u_gsci_ctl.stop_c();
    endtask
    task automatic wchk(input int i, input logic [15:0] e);
        chk("word", {q[i], q[i + 1]}, e);
        chk("crc", q[i + 2], crc8(e));
    endtask
    task automatic wait_rdy;
        repeat (6000) if (rdy !== 1'b1) @(posedge clk);
    endtask
    task automatic t_power;
        probe(8'hc4, 1'b0);
        wait_rdy();
        chk("ready", rdy, 1'b1);
        probe(8'hc6, 1'b0);
        probe(8'hc4, 1'b1);
    endtask
    task automatic t_write;
        cmd(16'h241d, 1'b1, 16'h07e6, crc8(16'h07e6));
        chk("toff", sets.toff, 16'h07e6);
        chk("code", code, 16'h241d);
        cmd(16'h2427, 1'b1, 16'h0042, ~crc8(16'h0042));
        chk("alt", sets.alt, 16'h0000);
        cmd(16'h2318);
        rd(3);
        wchk(0, 16'h07e6);
    endtask
    task automatic t_cal;
        cmd(16'h362f);
        probe(8'hc5, 1'b0);
        repeat (410 * CYC) @(posedge clk);
        cmd(16'h362f);
        repeat (410 * CYC) @(posedge clk);
        rd(3);
        wchk(0, cal);
    endtask
    task automatic t_periodic;
        cmd(16'h21b1);
        chk("mode", per, 1'b1);
        cmd(16'h3615);
        chk("code", code, 16'h21b1);
        cmd(16'he000, 1'b1, 16'h03f2, crc8(16'h03f2));
        chk("pres", sets.pres, 16'h03f2);
        cmd(16'hec05);
        probe(8'hc5, 1'b0);
        repeat (5000 * CYC) @(posedge clk);
        cmd(16'hec05);
        rd(9);
        wchk(0, meas.co2);
        wchk(3, meas.temp);
        wchk(6, meas.rh);
        cmd(16'hec05);
        probe(8'hc5, 1'b0);
        cmd(16'h3f86);
        repeat (510 * CYC) @(posedge clk);
        chk("mode", per, 1'b0);
    endtask
    task automatic t_reinit;
        cmd(16'h3646);
        chk("ready", rdy, 1'b0);
        wait_rdy();
        chk("ready", rdy, 1'b1);
    endtask
    // Cut a hang short
    always @(posedge clk) begin
        if (++cyc == 80000) begin
            err_total++;
            results();
        end
    end
    initial begin
        rst_n = 1'b0;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        t_power();
        t_write();
        t_cal();
        t_periodic();
        t_reinit();
        results();
    end
endmodule
